// *** inc/ufc_regs.svh ***
// Register indices, field positions, reset values and counts of the UART FIFO control block.
// Assumes an APB master that addresses each register as one aligned 32-bit word.
//
// What this block does
// - Transmit close-flush bit set: disabling transmit port empties the transmit FIFO.
// - Transmit open-flush bit set (default): enabling transmit port empties the transmit FIFO.
// - Receive close-flush bit set: disabling receive port empties the receive FIFO.
// - Receive open-flush bit set (default): enabling receive port empties the receive FIFO.
// - Writing one to receive flush bit 0 empties the receive FIFO; self-clearing.
// - Ten-bit read-only byte counts report each FIFO's current fill.
// - Transmit wide-mode enable selects wide transmit, else normal 5 to 9 bits.
// - Receive wide-mode enable selects wide receive, else normal 5 to 9 bits.
// - Standard serial class driver choosing baud below 40,960 sets low latency.
// - Without low latency, hold bulk-in data until packet full or 3 characters.
// - With the standard serial class driver the packet size is 63 bytes.
// - With low latency, forward available receive data at once per bulk-in request.
// - Assert flow control when receive fill reaches threshold, reset value 450.
// - One threshold serves both hardware and software flow control.
`ifndef UFC_REGS_SVH
`define UFC_REGS_SVH

`define UFC_IDX_TX_FLUSH 10'h040
`define UFC_IDX_TX_LEVEL 10'h041
`define UFC_IDX_TX_WIDE 10'h042
`define UFC_IDX_RX_FLUSH 10'h043
`define UFC_IDX_RX_LEVEL 10'h044
`define UFC_IDX_RX_WIDE 10'h045
`define UFC_IDX_IMM_FWD 10'h046
`define UFC_IDX_RX_THR 10'h047

`define UFC_FLUSH_RESET_BIT 0
`define UFC_FLUSH_OPEN_BIT 1
`define UFC_FLUSH_CLOSE_BIT 2
`define UFC_EN_BIT 0
`define UFC_CNT_W 10

`define UFC_OPEN_RST 1'h1
`define UFC_CLOSE_RST 1'h0
`define UFC_THR_RST 10'h1c2
`define UFC_BAUD_LIMIT 24'h00_a000
`define UFC_PKT_NORMAL 7'h40
`define UFC_PKT_STD 7'h3f
`define UFC_TMO_CHARS 2'h3

`define UFC_FIFO_DEPTH 512
`define UFC_FIFO_AW 9
`define UFC_OB_DEPTH 16
`define UFC_OB_AW 4

`endif

// *** inc/ufc_pkg.sv ***
// Types shared by the UART FIFO control block.
// Assumes the constants header is compiled alongside.
package ufc_pkg;

  typedef enum logic [1:0] {
    UFC_FW_IDLE = 2'h0,
    UFC_FW_WAIT = 2'h1,
    UFC_FW_MOVE = 2'h3
  } ufc_fw_state_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } ufc_beat_t;

  typedef struct packed {
    logic close_flush;
    logic open_flush;
  } ufc_flush_cfg_t;

endpackage

// *** src/ufc_top.sv ***
// FIFO storage and control for the transmit and receive byte paths of a USB-to-UART bridge.
// Assumes all inputs are synchronous to pclk and that char_tick pulses once per character time.
`timescale 1ns/1ps
`include "ufc_regs.svh"

module ufc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [AW:0] level
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] mcnt_q, mcnt_d, level_d;
  logic push, load, valid_d;

  // The output stage is a register so that downstream sees flop outputs; it counts in the level.
  assign push = in_valid && in_ready;
  assign load = (mcnt_q != '0) && (!out_valid || out_ready);
  assign mcnt_d = flush ? '0 : mcnt_q + (AW+1)'(push) - (AW+1)'(load);
  assign valid_d = flush ? 1'b0 : (load || (out_valid && !out_ready));
  assign level_d = mcnt_d + (AW+1)'(valid_d);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      mcnt_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
      mcnt_q <= '0;
    end else begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(load);
      mcnt_q <= mcnt_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= valid_d;
      if (load && !flush) begin
        out_data <= mem[rp_q];
      end
    end
  end

  // A registered ready means a full FIFO refuses the next beat without a combinational path.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= '0;
      in_ready <= 1'b0;
    end else begin
      level <= level_d;
      in_ready <= level_d < (AW+1)'(DEPTH);
    end
  end
endmodule

module ufc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic tx_port_en,
  input wire logic rx_port_en,
  input wire logic std_driver,
  input wire logic baud_set,
  input wire logic [23:0] baud_rate,
  input wire logic char_tick,
  input wire logic usb_out_valid,
  input wire logic [7:0] usb_out_data,
  output logic usb_out_ready,
  output logic ser_tx_valid,
  output logic [7:0] ser_tx_data,
  input wire logic ser_tx_ready,
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_data,
  output logic ser_rx_ready,
  input wire logic usb_in_req,
  output logic usb_in_valid,
  output ufc_pkg::ufc_beat_t usb_in_beat,
  input wire logic usb_in_ready,
  output logic tx_wide_en,
  output logic rx_wide_en,
  output logic imm_fwd_en,
  output logic flow_stop
);
  ufc_pkg::ufc_flush_cfg_t tx_cfg_q, rx_cfg_q;
  ufc_pkg::ufc_fw_state_t fw_q;
  ufc_pkg::ufc_beat_t ob_in;
  logic [9:0] thr_q, idx;
  logic tx_en_prev_q, rx_en_prev_q;
  logic tx_flush, rx_flush, wr_tx_reset, wr_rx_reset;
  logic wr_access, rd_setup, mapped;
  logic [`UFC_CNT_W-1:0] tx_level, rx_level;
  logic rx_out_valid, rx_out_ready, ob_in_ready, ob_in_valid;
  logic [7:0] rx_out_data;
  logic [6:0] pkt_size, mv_cnt_q;
  logic [1:0] tmo_q;
  logic release_ok, last_beat;
  logic [15:0] rd_val;

  assign idx = paddr[11:2];
  assign mapped = (paddr[1:0] == 2'h0) && (idx >= `UFC_IDX_TX_FLUSH) && (idx <= `UFC_IDX_RX_THR);
  assign rd_setup = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite && mapped;
  assign wr_rx_reset = wr_access && (idx == `UFC_IDX_RX_FLUSH) && pwdata[`UFC_FLUSH_RESET_BIT];
  assign wr_tx_reset = wr_access && (idx == `UFC_IDX_TX_FLUSH) && pwdata[`UFC_FLUSH_RESET_BIT];

  // Port edges are seen against the previous level; reset bits are never stored, so they self-clear.
  assign tx_flush = wr_tx_reset
    || (tx_port_en && !tx_en_prev_q && tx_cfg_q.open_flush)
    || (!tx_port_en && tx_en_prev_q && tx_cfg_q.close_flush);
  assign rx_flush = wr_rx_reset
    || (rx_port_en && !rx_en_prev_q && rx_cfg_q.open_flush)
    || (!rx_port_en && rx_en_prev_q && rx_cfg_q.close_flush);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_prev_q <= 1'b0;
      rx_en_prev_q <= 1'b0;
    end else begin
      tx_en_prev_q <= tx_port_en;
      rx_en_prev_q <= rx_port_en;
    end
  end

  // Zero-wait slave: read data is captured in the setup cycle and pready rises for the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      if (rd_setup) begin
        prdata <= (mapped && !pwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
        pslverr <= !mapped;
      end
    end
  end

  always_comb begin
    rd_val = 16'h0000;
    unique case (idx)
      `UFC_IDX_TX_FLUSH: rd_val = {13'h0000, tx_cfg_q.close_flush, tx_cfg_q.open_flush, 1'b0};
      `UFC_IDX_TX_LEVEL: rd_val = {6'h00, tx_level};
      `UFC_IDX_TX_WIDE: rd_val = {15'h0000, tx_wide_en};
      `UFC_IDX_RX_FLUSH: rd_val = {13'h0000, rx_cfg_q.close_flush, rx_cfg_q.open_flush, 1'b0};
      `UFC_IDX_RX_LEVEL: rd_val = {6'h00, rx_level};
      `UFC_IDX_RX_WIDE: rd_val = {15'h0000, rx_wide_en};
      `UFC_IDX_IMM_FWD: rd_val = {15'h0000, imm_fwd_en};
      `UFC_IDX_RX_THR: rd_val = {6'h00, thr_q};
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cfg_q <= '{close_flush: `UFC_CLOSE_RST, open_flush: `UFC_OPEN_RST};
      rx_cfg_q <= '{close_flush: `UFC_CLOSE_RST, open_flush: `UFC_OPEN_RST};
      thr_q <= `UFC_THR_RST;
    end else if (wr_access) begin
      if (idx == `UFC_IDX_TX_FLUSH) begin
        tx_cfg_q <= {pwdata[`UFC_FLUSH_CLOSE_BIT], pwdata[`UFC_FLUSH_OPEN_BIT]};
      end
      if (idx == `UFC_IDX_RX_FLUSH) begin
        rx_cfg_q <= {pwdata[`UFC_FLUSH_CLOSE_BIT], pwdata[`UFC_FLUSH_OPEN_BIT]};
      end
      if (idx == `UFC_IDX_RX_THR) begin
        thr_q <= pwdata[9:0];
      end
    end
  end

  // The serializer reads the wide-mode selects straight from these flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wide_en <= 1'b0;
      rx_wide_en <= 1'b0;
    end else if (wr_access) begin
      if (idx == `UFC_IDX_TX_WIDE) begin
        tx_wide_en <= pwdata[`UFC_EN_BIT];
      end
      if (idx == `UFC_IDX_RX_WIDE) begin
        rx_wide_en <= pwdata[`UFC_EN_BIT];
      end
    end
  end

  // The automatic set wins over a software write in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imm_fwd_en <= 1'b0;
    end else if (baud_set && std_driver && (baud_rate < `UFC_BAUD_LIMIT)) begin
      imm_fwd_en <= 1'b1;
    end else if (wr_access && idx == `UFC_IDX_IMM_FWD) begin
      imm_fwd_en <= pwdata[`UFC_EN_BIT];
    end
  end

  // One threshold output serves whichever flow control the UART has enabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_stop <= 1'b0;
    end else begin
      flow_stop <= (rx_level >= thr_q);
    end
  end

  ufc_fifo #(.W(8), .DEPTH(`UFC_FIFO_DEPTH), .AW(`UFC_FIFO_AW)) u_tx_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .flush(tx_flush),
    .in_valid(usb_out_valid),
    .in_data(usb_out_data),
    .in_ready(usb_out_ready),
    .out_valid(ser_tx_valid),
    .out_data(ser_tx_data),
    .out_ready(ser_tx_ready),
    .level(tx_level)
  );

  ufc_fifo #(.W(8), .DEPTH(`UFC_FIFO_DEPTH), .AW(`UFC_FIFO_AW)) u_rx_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .flush(rx_flush),
    .in_valid(ser_rx_valid),
    .in_data(ser_rx_data),
    .in_ready(ser_rx_ready),
    .out_valid(rx_out_valid),
    .out_data(rx_out_data),
    .out_ready(rx_out_ready),
    .level(rx_level)
  );

  // Bulk-in forwarding: a request opens a wait, then up to one packet moves to the endpoint.
  assign pkt_size = std_driver ? `UFC_PKT_STD : `UFC_PKT_NORMAL;
  assign release_ok = rx_out_valid && (imm_fwd_en
    || (rx_level >= 10'(pkt_size)) || (tmo_q == `UFC_TMO_CHARS));
  assign ob_in_valid = (fw_q == ufc_pkg::UFC_FW_MOVE) && rx_out_valid && !rx_flush;
  assign rx_out_ready = ob_in_valid && ob_in_ready;
  assign last_beat = ((mv_cnt_q + 7'h01) == pkt_size) || (rx_level == 10'h001);
  assign ob_in = '{last: last_beat, data: rx_out_data};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fw_q <= ufc_pkg::UFC_FW_IDLE;
      tmo_q <= 2'h0;
      mv_cnt_q <= 7'h00;
    end else begin
      unique case (fw_q)
        ufc_pkg::UFC_FW_IDLE: begin
          tmo_q <= 2'h0;
          mv_cnt_q <= 7'h00;
          if (usb_in_req) begin
            fw_q <= ufc_pkg::UFC_FW_WAIT;
          end
        end
        ufc_pkg::UFC_FW_WAIT: begin
          if (char_tick && tmo_q != `UFC_TMO_CHARS) begin
            tmo_q <= tmo_q + 2'h1;
          end
          if (release_ok && !rx_flush) begin
            fw_q <= ufc_pkg::UFC_FW_MOVE;
          end
        end
        ufc_pkg::UFC_FW_MOVE: begin
          if (rx_flush || !rx_out_valid) begin
            fw_q <= ufc_pkg::UFC_FW_IDLE;
          end else if (rx_out_ready) begin
            mv_cnt_q <= mv_cnt_q + 7'h01;
            if (last_beat) begin
              fw_q <= ufc_pkg::UFC_FW_IDLE;
            end
          end
        end
        default: fw_q <= ufc_pkg::UFC_FW_IDLE;
      endcase
    end
  end

  // A slow endpoint stalls the move state, and the receive FIFO then backs up to the serializer.
  ufc_fifo #(.W(9), .DEPTH(`UFC_OB_DEPTH), .AW(`UFC_OB_AW)) u_ob_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .flush(1'b0),
    .in_valid(ob_in_valid),
    .in_data(ob_in),
    .in_ready(ob_in_ready),
    .out_valid(usb_in_valid),
    .out_data(usb_in_beat),
    .out_ready(usb_in_ready),
    .level()
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_tx_open;
    tx_port_en && !tx_en_prev_q && tx_cfg_q.open_flush;
  endsequence
  sequence s_wait_full;
    fw_q == ufc_pkg::UFC_FW_WAIT && !imm_fwd_en && rx_out_valid && !rx_flush;
  endsequence

  a_tx_open_flush: assert property (s_tx_open |=> tx_level == 10'h000)
    else $error("Transmit FIFO not emptied on port enable.");
  a_tx_close_flush: assert property (
    (!tx_port_en && tx_en_prev_q && tx_cfg_q.close_flush) |=> tx_level == 10'h000)
    else $error("Transmit FIFO not emptied on port disable.");
  a_rx_open_flush: assert property (
    (rx_port_en && !rx_en_prev_q && rx_cfg_q.open_flush) |=> rx_level == 10'h000)
    else $error("Receive FIFO not emptied on port enable.");
  a_rx_close_keep: assert property (
    (!rx_port_en && rx_en_prev_q && !rx_cfg_q.close_flush && !wr_rx_reset
      && !ser_rx_valid && !rx_out_ready) |=> rx_level == $past(rx_level))
    else $error("Receive FIFO changed on disable with close flush clear.");
  a_rx_reset_write: assert property (wr_rx_reset |=> rx_level == 10'h000 ##1 !rx_out_valid)
    else $error("Receive reset write did not empty the FIFO.");
  a_tx_reset_write: assert property (wr_tx_reset |=> !ser_tx_valid && tx_level == 10'h000)
    else $error("Transmit reset write did not empty the FIFO.");
  a_level_read: assert property (
    (rd_setup && !pwrite && paddr == {`UFC_IDX_RX_LEVEL, 2'h0})
      |=> pready && prdata == {22'h00_0000, $past(rx_level)})
    else $error("Receive count read back wrong.");
  a_auto_latency: assert property (
    (baud_set && std_driver && baud_rate < `UFC_BAUD_LIMIT) |=> imm_fwd_en)
    else $error("Low latency not set for slow baud.");
  a_hold_packet: assert property (
    (s_wait_full and (tmo_q != `UFC_TMO_CHARS && rx_level < 10'(pkt_size)))
      |=> fw_q == ufc_pkg::UFC_FW_WAIT)
    else $error("Receive data forwarded before packet or timeout.");
  a_fwd_now: assert property (
    (fw_q == ufc_pkg::UFC_FW_WAIT && imm_fwd_en && rx_out_valid && !rx_flush)
      |=> fw_q == ufc_pkg::UFC_FW_MOVE ##2 (usb_in_valid || fw_q != ufc_pkg::UFC_FW_MOVE))
    else $error("Low latency data not forwarded at once.");
  a_flow_on: assert property ((rx_level >= thr_q) |=> flow_stop)
    else $error("Flow control not asserted at threshold.");
  a_flow_off: assert property ((rx_level < thr_q) |=> !flow_stop)
    else $error("Flow control not withdrawn below threshold.");
endmodule

// *** test/ufc_far_model.sv ***
// Far-side model: serializer sink for transmit bytes and host sink for bulk-in beats.
// Assumes valid/ready streams on pclk; stall inputs come from the bench.
`timescale 1ns/1ps
module ufc_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_stall,
  input wire logic in_stall,
  input wire logic ser_tx_valid,
  input wire logic [7:0] ser_tx_data,
  output logic ser_tx_ready,
  input wire logic usb_in_valid,
  input wire ufc_pkg::ufc_beat_t usb_in_beat,
  output logic usb_in_ready,
  output int n_tx,
  output int n_in,
  output int n_last,
  output logic [7:0] last_data,
  output logic [7:0] last_tx
);
  // Ready moves only just after an edge, so a beat is either taken whole or held.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_tx_ready <= 1'b0;
      usb_in_ready <= 1'b0;
      n_tx <= 0;
      n_in <= 0;
      n_last <= 0;
      last_data <= 8'h0;
      last_tx <= 8'h0;
    end else begin
      ser_tx_ready <= !tx_stall;
      usb_in_ready <= !in_stall;
      if (ser_tx_valid && ser_tx_ready) begin
        n_tx <= n_tx + 1;
        last_tx <= ser_tx_data;
      end
      if (usb_in_valid && usb_in_ready) begin
        n_in <= n_in + 1;
        last_data <= usb_in_beat.data;
        if (usb_in_beat.last) begin
          n_last <= n_in + 1;
        end
      end
    end
  end
endmodule

// *** test/uart_fifo_control_tb.sv ***
// Self-checking bench for the UART FIFO control block: APB tasks and stream pushes.
// Assumes the far-side model drains transmit bytes and takes bulk-in beats.
`timescale 1ns/1ps
`include "ufc_regs.svh"
module uart_fifo_control_tb;
  localparam logic [11:0] A_TXF = {`UFC_IDX_TX_FLUSH, 2'b00};
  localparam logic [11:0] A_RXF = {`UFC_IDX_RX_FLUSH, 2'b00};
  localparam logic [11:0] A_TXW = {`UFC_IDX_TX_WIDE, 2'b00};
  localparam logic [11:0] A_RXW = {`UFC_IDX_RX_WIDE, 2'b00};
  localparam logic [11:0] A_IMM = {`UFC_IDX_IMM_FWD, 2'b00};
  localparam logic [11:0] A_THR = {`UFC_IDX_RX_THR, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic tx_port_en = 1, rx_port_en = 1, std_driver = 0, baud_set = 0, char_tick = 0;
  logic [23:0] baud_rate = 0;
  logic usb_out_valid = 0, ser_rx_valid = 0, usb_in_req = 0, tx_stall = 1, in_stall = 1;
  logic [7:0] usb_out_data = 0, ser_rx_data = 0, ser_tx_data, last_data, last_tx;
  logic usb_out_ready, ser_tx_valid, ser_tx_ready, ser_rx_ready, usb_in_valid, usb_in_ready;
  ufc_pkg::ufc_beat_t usb_in_beat;
  logic tx_wide_en, rx_wide_en, imm_fwd_en, flow_stop;
  int fails = 0, n_tests = 0, cyc = 0, n_tx, n_in, n_last, base;
  always #20 pclk = ~pclk;
  ufc_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
    .pslverr, .tx_port_en, .rx_port_en, .std_driver, .baud_set, .baud_rate, .char_tick,
    .usb_out_valid, .usb_out_data, .usb_out_ready, .ser_tx_valid, .ser_tx_data, .ser_tx_ready,
    .ser_rx_valid, .ser_rx_data, .ser_rx_ready, .usb_in_req, .usb_in_valid, .usb_in_beat,
    .usb_in_ready, .tx_wide_en, .rx_wide_en, .imm_fwd_en, .flow_stop);
  ufc_far_model far (.pclk, .presetn, .tx_stall, .in_stall, .ser_tx_valid, .ser_tx_data,
    .ser_tx_ready, .usb_in_valid, .usb_in_beat, .usb_in_ready, .n_tx, .n_in, .n_last,
    .last_data, .last_tx);
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      $display("[FAIL] %0t run did not finish", $time);
      give_verdict();
    end
  end
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // The request is held until pready is seen high; one idle cycle keeps drivers race-free.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic push(input logic rx, input int n, input int first);
    for (int i = 0; i < n; i++) begin
      ser_rx_valid <= rx;
      usb_out_valid <= !rx;
      ser_rx_data <= 8'(first + i);
      usb_out_data <= 8'(first + i);
      do begin
        @(posedge pclk);
      end while ((rx ? ser_rx_ready : usb_out_ready) !== 1'b1);
    end
    ser_rx_valid <= 1'b0;
    usb_out_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic setport(input logic rx, input logic v);
    if (rx) rx_port_en <= v;
    else tx_port_en <= v;
    ticks(3);
  endtask
  task automatic pulse(input int which);
    usb_in_req <= (which == 0);
    char_tick <= (which == 1);
    baud_set <= (which == 2);
    @(posedge pclk);
    usb_in_req <= 1'b0;
    char_tick <= 1'b0;
    baud_set <= 1'b0;
    ticks(2);
  endtask
  task automatic flush_test(input logic rx);
    logic [11:0] fa;
    fa = rx ? A_RXF : A_TXF;
    push(rx, 5, 0);
    apb(1'b0, fa + 12'h4, 32'h0);
    chk_w(rdat, 32'h5);
    apb(1'b1, fa, 32'h3);
    apb(1'b0, fa + 12'h4, 32'h0);
    chk_w(rdat, 32'h0);
    push(rx, 3, 0);
    setport(rx, 1'b0);
    apb(1'b0, fa + 12'h4, 32'h0);
    chk_w(rdat, 32'h3);
    setport(rx, 1'b1);
    apb(1'b0, fa + 12'h4, 32'h0);
    chk_w(rdat, 32'h0);
    apb(1'b1, fa, 32'h4);
    push(rx, 3, 0);
    setport(rx, 1'b0);
    apb(1'b0, fa + 12'h4, 32'h0);
    chk_w(rdat, 32'h0);
    setport(rx, 1'b1);
    apb(1'b1, fa, 32'h0);
    push(rx, 2, 0);
    setport(rx, 1'b0);
    setport(rx, 1'b1);
    apb(1'b0, fa + 12'h4, 32'h0);
    chk_w(rdat, 32'h2);
    apb(1'b1, fa, 32'h3);
    $display("flush test done, receive side %b", rx);
  endtask
  initial begin
    ticks(20);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, A_TXF + 12'(4 * i), 32'h0);
      chk_w(rdat, (i == 0 || i == 3) ? 32'h2 : (i == 7) ? 32'h1c2 : 32'h0);
    end
    apb(1'b0, 12'h120, 32'h0);
    chk_b(rerr, 1'b1);
    chk_w(rdat, 32'h0);
    $display("reset test done");
    apb(1'b1, A_TXW, 32'h1);
    chk_b(tx_wide_en, 1'b1);
    apb(1'b1, A_RXW, 32'h1);
    chk_b(rx_wide_en, 1'b1);
    apb(1'b0, A_RXW, 32'h0);
    chk_w(rdat, 32'h1);
    apb(1'b1, A_TXW, 32'h0);
    chk_b(tx_wide_en, 1'b0);
    $display("wide test done");
    flush_test(1'b0);
    flush_test(1'b1);
    apb(1'b1, A_THR, 32'h4);
    push(1'b1, 3, 0);
    ticks(2);
    chk_b(flow_stop, 1'b0);
    push(1'b1, 1, 3);
    ticks(2);
    chk_b(flow_stop, 1'b1);
    apb(1'b1, A_IMM, 32'h1);
    in_stall <= 1'b0;
    base = n_in;
    pulse(0);
    ticks(30);
    chk_w(n_in - base, 32'h4);
    chk_w(n_last, n_in);
    chk_w(last_data, 32'h3);
    chk_b(flow_stop, 1'b0);
    $display("threshold test done");
    apb(1'b1, A_IMM, 32'h0);
    in_stall <= 1'b1;
    base = n_in;
    push(1'b1, 70, 0);
    pulse(0);
    ticks(40);
    chk_b(usb_in_valid, 1'b1);
    apb(1'b0, A_RXF + 12'h4, 32'h0);
    chk_w(rdat, 32'd54);
    in_stall <= 1'b0;
    ticks(120);
    chk_w(n_in - base, 32'd64);
    chk_w(n_last, n_in);
    chk_w(last_data, 32'h3f);
    base = n_in;
    pulse(0);
    ticks(30);
    pulse(1);
    pulse(1);
    ticks(20);
    chk_w(n_in - base, 32'h0);
    pulse(1);
    ticks(30);
    chk_w(n_in - base, 32'h6);
    std_driver <= 1'b1;
    base = n_in;
    push(1'b1, 70, 0);
    pulse(0);
    ticks(150);
    chk_w(n_in - base, 32'd63);
    chk_w(last_data, 32'h3e);
    apb(1'b1, A_RXF, 32'h3);
    $display("packet test done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, A_IMM, 32'h0);
      baud_rate <= (i == 0) ? 24'h00_a000 : (i == 1) ? 24'h00_9fff : 24'h00_04b0;
      std_driver <= (i != 2);
      pulse(2);
      chk_b(imm_fwd_en, i == 1);
    end
    tx_stall <= 1'b0;
    push(1'b0, 4, 0);
    ticks(10);
    chk_w(n_tx, 32'h4);
    chk_w(last_tx, 32'h3);
    $display("baud and drain test done");
    give_verdict();
  end
endmodule
